/* File: pkg/mss_pkg.sv */
`default_nettype none
// Shared constants for the memory self-test run supervisor
package mss_pkg;
  // Width of the run timer and of the normal-time reference
  localparam int TIME_W        = 32;
  // Timeout threshold as percent of the normal time
  localparam int TIMEOUT_PCT   = 120;
  // Short-run threshold as percent of the normal time
  localparam int SHORT_PCT     = 80;
  // Divisor for percent arithmetic
  localparam int PCT_DIV       = 100;
  // Default retry limit before giving up
  localparam int MAX_RETRY     = 8;
  // Reset value of the retry counter
  localparam logic [7:0] RETRY_RST = 8'h00;

  // Supervisor states, one-hot
  typedef enum logic [4:0] {
    MSS_IDLE   = 5'b00001,
    MSS_LAUNCH = 5'b00010,
    MSS_WAIT   = 5'b00100,
    MSS_JUDGE  = 5'b01000,
    MSS_DONE   = 5'b10000
  } mss_state_e;
endpackage : mss_pkg
`default_nettype wire

/* File: rtl/mss_run_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// Elapsed counter that advances only while run is high, cleared at launch, saturating
module mss_run_timer #(
  parameter int W = mss_pkg::TIME_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         run,
  output logic [W-1:0]      count
);
  // Saturation guard
  wire atMax = &count;

  // Counts every enabled cycle while a run is in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (ce)
    begin
      if (clear)
        count <= '0;
      else if (run && !atMax)
        count <= count + 1'b1;
    end
  end
endmodule : mss_run_timer
`default_nettype wire

/* File: rtl/mss_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
module mss_supervisor #(
  parameter int W         = mss_pkg::TIME_W,
  parameter int MAX_RETRY = mss_pkg::MAX_RETRY
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] normalTime,
  input  wire logic         testDone,
  input  wire logic         testPass,
  output logic              testLaunch,
  output logic              busy,
  output logic              resultValid,
  output logic              resultPass,
  output logic              timeoutErr,
  output logic              retryExhausted,
  output logic              shortRunSeen,
  output logic [7:0]        retryCount
);
  mss_pkg::mss_state_e state_r;
  mss_pkg::mss_state_e state_nxt;

  // Registered outputs and their next values
  logic       launch_r, launch_nxt;
  logic       valid_r, valid_nxt;
  logic       pass_r, pass_nxt;
  logic       tmo_r, tmo_nxt;
  logic       exh_r, exh_nxt;
  logic       short_r, short_nxt;
  logic [7:0] retryCount_r, retryCount_nxt;

  // Elapsed-time counter outputs and controls
  logic [W-1:0] elapsed;
  wire          timerClear = (state_r == mss_pkg::MSS_LAUNCH);
  wire          timerRun   = (state_r == mss_pkg::MSS_WAIT);

  // Thresholds derived from the reference, widened to avoid overflow
  wire [W+7:0] normWide  = {8'h00, normalTime};
  wire [W+7:0] elapWide  = {8'h00, elapsed};
  // Elapsed time scaled by the percent divisor
  wire [W+7:0] elapPct   = elapWide * (W+8)'(mss_pkg::PCT_DIV);
  // Limits scaled by percent, so no division is needed
  wire [W+7:0] limitHi   = normWide * (W+8)'(mss_pkg::TIMEOUT_PCT);
  wire [W+7:0] limitLo   = normWide * (W+8)'(mss_pkg::SHORT_PCT);
  // Timeout when elapsed exceeds 120% of normal
  wire         overTime  = (elapPct > limitHi);
  // Too short when elapsed below 80% of normal
  wire         tooShort  = (elapPct < limitLo);
  // Short passing result is a hidden non-execution
  wire         fakePass  = tooShort && testPass;
  // Another relaunch is still allowed
  wire         retryLeft = (retryCount_r < 8'(MAX_RETRY));

  // Run timer, counts without interruption during a run
  mss_run_timer #(
    .W (W)
  ) uTimer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (timerClear),
    .run   (timerRun),
    .count (elapsed)
  );

  // Next-state and output decision
  always_comb
  begin
    state_nxt      = state_r;
    launch_nxt     = 1'b0;
    valid_nxt      = valid_r;
    pass_nxt       = pass_r;
    tmo_nxt        = tmo_r;
    exh_nxt        = exh_r;
    short_nxt      = short_r;
    retryCount_nxt = retryCount_r;
    case (state_r)
      // Idle: results of the last request stay on show
      mss_pkg::MSS_IDLE:
      begin
        // New request clears previous results
        if (start)
        begin
          valid_nxt      = 1'b0;
          pass_nxt       = 1'b0;
          tmo_nxt        = 1'b0;
          exh_nxt        = 1'b0;
          short_nxt      = 1'b0;
          retryCount_nxt = mss_pkg::RETRY_RST;
          state_nxt      = mss_pkg::MSS_LAUNCH;
        end
      end
      // Launch: timer cleared while the pulse is issued
      mss_pkg::MSS_LAUNCH:
      begin
        // One-cycle launch pulse to the controller
        launch_nxt = 1'b1;
        state_nxt  = mss_pkg::MSS_WAIT;
      end
      // Wait: timer runs until completion or timeout
      mss_pkg::MSS_WAIT:
      begin
        // Completion is judged next cycle; timeout wins if it comes first
        if (testDone)
          state_nxt = mss_pkg::MSS_JUDGE;
        else if (overTime)
        begin
          // Run overran; abandon it
          tmo_nxt   = 1'b1;
          state_nxt = mss_pkg::MSS_DONE;
        end
      end
      // Judge: classify the finished run by its length
      mss_pkg::MSS_JUDGE:
      begin
        if (overTime)
        begin
          // Late completion counts as timeout
          tmo_nxt   = 1'b1;
          state_nxt = mss_pkg::MSS_DONE;
        end
        else if (tooShort)
        begin
          // Any short run is not executed; relaunch while allowed
          short_nxt = short_r | fakePass;
          if (retryLeft)
          begin
            // Relaunch and count the attempt
            retryCount_nxt = retryCount_r + 8'h01;
            state_nxt      = mss_pkg::MSS_LAUNCH;
          end
          else
          begin
            // Give up rather than loop forever
            exh_nxt   = 1'b1;
            state_nxt = mss_pkg::MSS_DONE;
          end
        end
        else
        begin
          // Properly timed run; latch valid with the controller's pass status
          valid_nxt = 1'b1;
          pass_nxt  = testPass;
          state_nxt = mss_pkg::MSS_DONE;
        end
      end
      // Done: flags latched, drop back to idle
      mss_pkg::MSS_DONE:
      begin
        state_nxt = mss_pkg::MSS_IDLE;
      end
      // Illegal code; recover to idle
      default:
      begin
        state_nxt = mss_pkg::MSS_IDLE;
      end
    endcase
  end

  // State and output registers, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Power-on: idle with every flag clear
      state_r      <= mss_pkg::MSS_IDLE;
      launch_r     <= 1'b0;
      valid_r      <= 1'b0;
      pass_r       <= 1'b0;
      tmo_r        <= 1'b0;
      exh_r        <= 1'b0;
      short_r      <= 1'b0;
      retryCount_r <= mss_pkg::RETRY_RST;
    end
    else if (ce)
    begin
      state_r      <= state_nxt;
      launch_r     <= launch_nxt;
      valid_r      <= valid_nxt;
      pass_r       <= pass_nxt;
      tmo_r        <= tmo_nxt;
      exh_r        <= exh_nxt;
      short_r      <= short_nxt;
      retryCount_r <= retryCount_nxt;
    end
  end

  // Busy flag registered alongside the state
  logic busy_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_r <= 1'b0;
    else if (ce)
      busy_r <= (state_nxt != mss_pkg::MSS_IDLE);
  end

  // Outputs straight from flip-flops
  assign testLaunch     = launch_r;
  assign busy           = busy_r;
  assign resultValid    = valid_r;
  assign resultPass     = pass_r;
  assign timeoutErr     = tmo_r;
  assign retryExhausted = exh_r;
  assign shortRunSeen   = short_r;
  assign retryCount     = retryCount_r;
endmodule : mss_supervisor
`default_nettype wire

/* File: verif/mss_supervisor_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the run supervisor
module mss_supervisor_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       start,
  input wire logic       busy,
  input wire logic       testLaunch,
  input wire logic       resultValid,
  input wire logic       resultPass,
  input wire logic       timeoutErr,
  input wire logic       retryExhausted,
  input wire logic [7:0] retryCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_go; start && ce && !busy |-> ##[2:3] testLaunch; endproperty
  a_go: assert property (p_go) else $error("no launch");
  property p_pl; testLaunch |=> !testLaunch; endproperty
  a_pl: assert property (p_pl) else $error("long launch");
  property p_ex; resultValid |-> !timeoutErr && !retryExhausted; endproperty
  a_ex: assert property (p_ex) else $error("mixed flags");
  property p_qt; !busy |-> !testLaunch; endproperty
  a_qt: assert property (p_qt) else $error("idle launch");
  property p_hd; !busy && !start |=> $stable({resultValid, resultPass, timeoutErr}); endproperty
  a_hd: assert property (p_hd) else $error("flag moved");
  property p_dn; $rose(resultValid) |-> ##[1:2] !busy; endproperty
  a_dn: assert property (p_dn) else $error("busy stuck");
  property p_rt; $changed(retryCount) && retryCount != 8'h00
    |-> ##[0:4] (testLaunch || retryExhausted); endproperty
  a_rt: assert property (p_rt) else $error("no relaunch");
  property p_to; $rose(timeoutErr) |-> ##[0:2] !busy; endproperty
  a_to: assert property (p_to) else $error("timeout stuck");
  c_ok: cover property (resultValid && resultPass);
  c_to: cover property (timeoutErr);
  c_ex: cover property (retryExhausted);
endmodule : mss_supervisor_asserts
bind mss_supervisor mss_supervisor_asserts u_chk (.clk, .rst_n, .ce, .start, .busy,
  .testLaunch, .resultValid, .resultPass, .timeoutErr, .retryExhausted, .retryCount);
`default_nettype wire

/* File: verif/mss_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-test controller model: short passing runs first, then timed runs
module mss_ctrl_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        testLaunch,
  input  wire logic        pass,
  input  wire logic [7:0]  nShort,
  input  wire logic [15:0] dly,
  output logic             testDone,
  output logic             testPass
);
  logic [15:0] cnt;  // Cycles left in the run, 0 means none or hung
  logic [7:0]  left; // Short runs still to give
  logic        ps;   // Status of the current run
  // Run timing; status is junk outside its two valid cycles
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {cnt, left, ps, testDone, testPass} <= '0;
    else
    begin
      testDone <= (cnt == 16'h0001);
      testPass <= (cnt == 16'h0001 || testDone) ? ps : ~testPass;
      cnt <= (cnt > 16'h0001) ? cnt - 16'h0001 : 16'h0000;
      if (start)
        left <= nShort;
      if (testLaunch)
      begin
        cnt  <= (left != 8'h00) ? 16'h000a : dly;
        ps   <= (left != 8'h00) | pass;
        left <= (left != 8'h00) ? left - 8'h01 : left;
      end
    end
endmodule : mss_ctrl_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the run supervisor
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, pass = 1'b0, pb = 1'b0;
  logic [31:0] nt = 32'h64;
  logic [15:0] dly = 16'h64;
  logic [7:0]  nShort = 8'h00, retryCount;
  logic        testDone, testPass, testLaunch, busy, resultValid, resultPass;
  logic        timeoutErr, retryExhausted, shortRunSeen;
  logic [12:0] expQ[$]; // Expected {valid, pass, timeout, exhausted, short, retries}
  logic [31:0] n;
  logic        p;
  int          num_errors = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  mss_supervisor #(.MAX_RETRY(2)) dut (.clk, .rst_n, .ce(1'b1), .start, .normalTime(nt),
    .testDone, .testPass, .testLaunch, .busy, .resultValid, .resultPass, .timeoutErr,
    .retryExhausted, .shortRunSeen, .retryCount);
  mss_ctrl_model u_ctl (.clk, .rst_n, .start, .testLaunch, .pass, .nShort, .dly,
    .testDone, .testPass);
  // Compare and count
  task check(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Counts and verdict
  task give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // One supervised request, waited out under a bound
  task run(input logic [31:0] nn, input logic pp, input logic [7:0] s,
           input logic [15:0] d, input logic [12:0] e);
    int i;
    nt = nn;
    pass = pp;
    nShort = s;
    dly = d;
    start = 1'b1;
    expQ.push_back(e);
    @(negedge clk) start = 1'b0;
    for (i = 0; i < 3000 && (i < 3 || busy !== 1'b0); i++) @(negedge clk);
    if (i == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  endtask : run
  // Watch the end of each request
  always @(negedge clk)
  begin
    if (pb && busy === 1'b0)
      check({resultValid, resultPass, timeoutErr, retryExhausted, shortRunSeen,
             retryCount}, expQ.pop_front());
    pb = busy;
  end
  // Main sequence
  initial
  begin
    void'($urandom(48));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    run(32'h64, 1'b1, 8'h00, 16'h64, 13'h1800);
    run(32'h64, 1'b0, 8'h00, 16'h64, 13'h1000);
    run(32'h64, 1'b1, 8'h01, 16'h64, 13'h1901);
    run(32'h64, 1'b1, 8'h08, 16'h64, 13'h0302);
    run(32'h64, 1'b1, 8'h00, 16'h00, 13'h0400);
    repeat (4)
    begin
      n = 32'h32 + ($urandom % 50);
      p = 1'($urandom);
      run(n, p, 8'h00, n[15:0], {1'b1, p, 11'h000});
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
